// ===== bench/lfd_chk.sv
`timescale 1ns/10ps
module lfd_chk (
    input wire        pclk,
    input wire        presetn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [12:0] paddr,
    input wire [31:0] prdata,
    input wire        pready,
    input wire        pslverr,
    input wire        frame_out,
    input wire [15:0] com_out,
    input wire [55:0] seg_out,
    input wire [15:0] shared_out
);
    // ------------------------
    // Bus and pin properties.
    // ------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    req_answer_a:
        assert property (psel && !penable |=> pready) else $error("no answer");
    ready_pulse_a:
        assert property (pready |=> !pready) else $error("ready too long");
    err_ready_a:
        assert property (pslverr |-> pready) else $error("stray error");
    rdata_idle_a:
        assert property (!pready |-> prdata == 32'h0) else $error("stray data");
    err_map_a:
        assert property (pready && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 13'h08FC
            && paddr != 13'h1000 && paddr != 13'h1004)) else $error("bad error map");
    ram_byte_a:
        assert property (pready && !pwrite && paddr < 13'h0900 |-> prdata[31:8] == 24'h0)
            else $error("wide ram data");
    com_onehot_a:
        assert property ($onehot0(com_out)) else $error("several commons");
    seg_slot_a:
        assert property ($changed(seg_out) |-> $changed(com_out) || $changed(shared_out))
            else $error("segments moved mid slot");
    cover property (pready && pwrite);
    cover property (pslverr);
    cover property ($rose(frame_out));
endmodule // lfd_chk
bind lfd_top lfd_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_out(frame_out), .com_out(com_out), .seg_out(seg_out), .shared_out(shared_out));

// ===== bench/lfd_panel.sv
`timescale 1ns/10ps
module lfd_panel (
    input  wire         pclk,
    input  wire         duty32,
    input  wire  [15:0] com_out,
    input  wire  [55:0] seg_out,
    input  wire  [15:0] shared_out,
    output logic [31:0] act_com,
    output logic [71:0] seg_all,
    output logic        order_err
);
    logic [31:0] prev_r;
    integer      k;
    // ----------------------------
    // Pin decode and scan order.
    // ----------------------------
    always @* begin
        act_com = duty32 ? {shared_out, com_out} : {16'h0000, com_out};
        seg_all = {16'h0000, seg_out};
        for (k = 0; k < 16; k = k + 1)
            if (!duty32) seg_all[71 - k] = shared_out[k];
    end
    initial order_err = 1'b0;
    always @(posedge pclk) begin
        prev_r <= act_com;
        if ($onehot(act_com) && $onehot(prev_r) && act_com != prev_r && act_com !=
            ((prev_r == (duty32 ? 32'h80000000 : 32'h00008000)) ? 32'h1 : prev_r << 1))
            order_err <= 1'b1;
    end
endmodule // lfd_panel

// ===== bench/lfd_top_tb.sv
`timescale 1ns/10ps
`include "lfd_map.vh"
module lfd_top_tb;
    logic        pclk = 1'b0, presetn = 1'b0, duty32 = 1'b1;
    logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
    logic [12:0] paddr = 13'h0000;
    logic [31:0] pwdata = 32'h0, rd;
    logic [1:0]  osc_r = 2'h0;
    logic [8:0]  f0;
    wire  [31:0] prdata, act_com;
    wire         pready, pslverr, frame_out, order_err;
    wire  [15:0] com_out, shared_out;
    wire  [55:0] seg_out;
    wire  [71:0] seg_all;
    int          fails = 0, compares = 0, n, i, t;
    int          cfg[4] = '{32'h102, 32'h10E, 32'h101, 32'h105};
    int          slot[4] = '{5, 26, 3, 3};
    int          pin[4] = '{9, 46, 60, 11};
    always #5 pclk = ~pclk;
    always @(posedge pclk) osc_r <= osc_r + 2'h1;
    lfd_top u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_speed_oscillator(osc_r[1]), .high_speed_oscillator(osc_r[1]),
        .frame_out(frame_out), .com_out(com_out), .seg_out(seg_out), .shared_out(shared_out));
    lfd_panel u_panel (.pclk(pclk), .duty32(duty32), .com_out(com_out), .seg_out(seg_out),
        .shared_out(shared_out), .act_com(act_com), .seg_all(seg_all), .order_err(order_err));
    // --------------------
    // Bus and wait tasks.
    // --------------------
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [12:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (t = 0; t < 50 && pready !== 1'b1; t++) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_frame();
        logic f;
        f = frame_out;
        for (t = 0; t < 5000 && frame_out === f; t++) @(posedge pclk);
    endtask
    task automatic tally_and_finish();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    initial begin
        #1000000;
        fails++;
        tally_and_finish();
    end
    // ------------
    // Test steps.
    // ------------
    initial begin
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, `LFD_CTRL_ADDR, 32'h0);
        chk(rd, 32'h102);
        for (i = 0; i < 576; i++)
            apb(1'b1, 13'(i * 4), (i == 36) ? 32'h20 : (i == 120) ? 32'h8 : 32'h0);
        for (i = 0; i < 4; i++) begin
            apb(1'b1, `LFD_CTRL_ADDR, cfg[i]);
            duty32 <= cfg[i][1];
            wait_frame();
            wait_frame();
            chk(t, `LFD_FRAME_TICKS * 4);
            for (t = 0; t < 5000 && act_com !== (32'h1 << slot[i]); t++) @(posedge pclk);
            chk(seg_all, 72'h1 << pin[i]);
        end
        for (i = 0; i < 4; i += 3) begin
            apb(1'b1, `LFD_CTRL_ADDR, 32'h100 | i);
            for (t = 0; t < 1000 && (com_out | shared_out) !== 16'h0; t++) @(posedge pclk);
            chk(seg_out, 72'h0);
            apb(1'b0, `LFD_CTRL_ADDR, 32'h0);
            chk(rd, 32'h100 | i);
        end
        duty32 <= 1'b1;
        for (i = 0; i < 6; i++) begin
            apb(1'b1, `LFD_CTRL_ADDR, 32'h112 | (i << 5));
            n = (128 << ((i > 4) ? 4 : i)) * 3;
            repeat (n) @(posedge pclk);
            apb(1'b0, `LFD_STAT_ADDR, 32'h0);
            f0 = rd[15:7];
            repeat (n - 3) @(posedge pclk);
            apb(1'b0, `LFD_STAT_ADDR, 32'h0);
            chk(9'(rd[15:7] - f0), 9'h3);
        end
        apb(1'b1, `LFD_RAM_LAST_ADDR, 32'hA5);
        apb(1'b0, `LFD_RAM_LAST_ADDR, 32'h0);
        apb(1'b1, `LFD_RAM_LAST_ADDR, rd | 32'h2);
        apb(1'b0, `LFD_RAM_LAST_ADDR, 32'h0);
        chk(rd, 32'hA7);
        apb(1'b0, 13'h0090, 32'h0);
        chk(rd, 32'h20);
        apb(1'b0, 13'h0900, 32'h0);
        chk(er, 1'b1);
        chk(order_err, 1'b0);
        tally_and_finish();
    end
endmodule // lfd_top_tb

// ===== hdl/lfd_map.vh
`ifndef LFD_MAP_VH
`define LFD_MAP_VH
// -----------------------------------------------------------------
// Register map.
// -----------------------------------------------------------------
`define LFD_ADDR_W        13
`define LFD_RAM_BASE      13'h0000
`define LFD_RAM_BYTES     576
`define LFD_RAM_LAST_ADDR 13'h08FC
`define LFD_CTRL_ADDR     13'h1000
`define LFD_STAT_ADDR     13'h1004
// -----------------------------------------------------------------
// Control fields and reset values.
// -----------------------------------------------------------------
`define LFD_DUTY_LSB      0
`define LFD_DUTY_MSB      1
`define LFD_SEGREV_BIT    2
`define LFD_COMMON_ORDER_REVERSE_BIT    3
`define LFD_SRC_BIT       4
`define LFD_HSDIV_LSB     5
`define LFD_HSDIV_MSB     7
`define LFD_ENABLE_BIT    8
`define LFD_DUTY_RST      2'h2
`define LFD_DUTY_32       2'h2
`define LFD_DUTY_16       2'h1
`define LFD_HSDIV_RST     3'h0
`define LFD_HSDIV_MAX     3'h4
`define LFD_ENABLE_RST    1'b1
// -----------------------------------------------------------------
// Timing counts.
// -----------------------------------------------------------------
`define LFD_FR_DIV        1024
`define LFD_FRAME_TICKS   (`LFD_FR_DIV / 2)
`define LFD_HSDIV_BASE    32
`define LFD_NSEG_32       7'd56
`define LFD_NSEG_16       7'd72
`define LFD_NCOM_32       5'd31
`define LFD_NCOM_16       5'd15
`endif

// ===== hdl/lfd_top.v
// Decided for this implementation: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
// What this block does
// - Frame signal comes from the LCD clock divided by 1024.
// - Low-speed 32.768 kHz source gives a nominal 32 Hz frame.
// - High-speed source is first divided by 1/32 up to 1/512.
// - Duty code 2 is 1/32, code 1 is 1/16, 0 and 3 reserved, reset 2.
// - 1/32 drives COM0-31 and SEG0-55; 1/16 drives COM0-15 and SEG0-71.
// - Shared pins are COM16-31 at 1/32 and SEG71-56 at 1/16.
// - A 576-byte display RAM is readable and writable from the CPU bus.
// - Bit-to-pixel mapping follows duty, segment reverse and common reverse.
// - A 1 bit lights its pixel, a 0 bit blanks it.
// - Display RAM behaves as plain RAM for read-modify-write.
// - Bytes not shown on the panel are general-purpose storage.
// - The LCD clock is generated in the oscillator unit clock generator; lfd_top derives it itself from its two oscillator inputs.
`include "lfd_map.vh"
module lfd_top (
    input  wire                   pclk,
    input  wire                   presetn,
    input  wire                   psel,
    input  wire                   penable,
    input  wire                   pwrite,
    input  wire [`LFD_ADDR_W-1:0] paddr,
    input  wire [31:0]            pwdata,
    output reg  [31:0]            prdata,
    output reg                    pready,
    output reg                    pslverr,
    input  wire                   low_speed_oscillator,
    input  wire                   high_speed_oscillator,
    output reg                    frame_out,
    output reg  [15:0]            com_out,
    output reg  [55:0]            seg_out,
    output reg  [15:0]            shared_out
);

// -----------------------------------------------------------------
// Control register and display RAM.
// -----------------------------------------------------------------
reg  [1:0]  duty_select_field_r;
reg         seg_rev_r;
reg         common_order_reverse_r;
reg         src_hs_r;
reg  [2:0]  high_speed_divider_ratio_r;
reg         enable_r;
reg  [7:0]  mem [0:`LFD_RAM_BYTES-1];

wire        setup_ph  = psel & ~penable;
wire        access_ph = psel & penable & pready;
wire        is_ram    = (paddr <= `LFD_RAM_LAST_ADDR);
wire        is_ctrl   = (paddr == `LFD_CTRL_ADDR);
wire        is_stat   = (paddr == `LFD_STAT_ADDR);
wire [9:0]  ram_idx   = paddr[11:2];
wire        duty32    = (duty_select_field_r == `LFD_DUTY_32);
wire        duty16    = (duty_select_field_r == `LFD_DUTY_16);
wire        show      = enable_r & (duty32 | duty16);

reg  [4:0]  cur_com_r;
reg  [8:0]  frame_cnt_r;

always @(posedge pclk) begin
    if (access_ph && pwrite && is_ram) begin
        mem[ram_idx] <= pwdata[7:0];
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        duty_select_field_r        <= `LFD_DUTY_RST;
        seg_rev_r                  <= 1'b0;
        common_order_reverse_r     <= 1'b0;
        src_hs_r                   <= 1'b0;
        high_speed_divider_ratio_r <= `LFD_HSDIV_RST;
        enable_r                   <= `LFD_ENABLE_RST;
    end else if (access_ph && pwrite && is_ctrl) begin
        duty_select_field_r        <= pwdata[`LFD_DUTY_MSB:`LFD_DUTY_LSB];
        seg_rev_r                  <= pwdata[`LFD_SEGREV_BIT];
        common_order_reverse_r     <= pwdata[`LFD_COMMON_ORDER_REVERSE_BIT];
        src_hs_r                   <= pwdata[`LFD_SRC_BIT];
        high_speed_divider_ratio_r <= pwdata[`LFD_HSDIV_MSB:`LFD_HSDIV_LSB];
        enable_r                   <= pwdata[`LFD_ENABLE_BIT];
    end
end

// -----------------------------------------------------------------
// APB read data, prepared during the setup cycle.
// -----------------------------------------------------------------
reg  [31:0] prdata_nxt;

always @* begin
    prdata_nxt = 32'h0000_0000;
    if (setup_ph && !pwrite) begin
        if (is_ram) begin
            prdata_nxt = {24'h00_0000, mem[ram_idx]};
        end else if (is_ctrl) begin
            prdata_nxt = {23'h00_0000, enable_r, high_speed_divider_ratio_r,
                          src_hs_r, common_order_reverse_r, seg_rev_r,
                          duty_select_field_r};
        end else if (is_stat) begin
            prdata_nxt = {16'h0000, frame_cnt_r, frame_out, show, cur_com_r};
        end
    end
end

// -----------------------------------------------------------------
// APB answer, one access cycle.
// -----------------------------------------------------------------
always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        pready  <= 1'b0;
        pslverr <= 1'b0;
        prdata  <= 32'h0000_0000;
    end else begin
        pready  <= setup_ph;
        pslverr <= setup_ph & ~(is_ram | is_ctrl | is_stat);
        prdata  <= prdata_nxt;
    end
end

// -----------------------------------------------------------------
// Oscillator input synchronisers and LCD clock generator.
// -----------------------------------------------------------------
reg  [2:0]  ls_sync_r;
reg  [2:0]  hs_sync_r;
reg         ls_lvl_r;
reg         hs_lvl_r;
reg  [8:0]  hs_div_r;
reg         lcd_tick_r;

wire        ls_chg   = (ls_sync_r[1] == ls_sync_r[2]) & (ls_sync_r[2] != ls_lvl_r);
wire        hs_chg   = (hs_sync_r[1] == hs_sync_r[2]) & (hs_sync_r[2] != hs_lvl_r);
wire        ls_rise  = ls_chg & ls_sync_r[2];
wire        hs_rise  = hs_chg & hs_sync_r[2];
wire [2:0]  hs_ratio = (high_speed_divider_ratio_r > `LFD_HSDIV_MAX) ?
                       `LFD_HSDIV_MAX : high_speed_divider_ratio_r;
wire [9:0]  hs_span  = 10'd`LFD_HSDIV_BASE << hs_ratio;
wire [8:0]  hs_last  = hs_span[8:0] - 9'd1;

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        ls_sync_r  <= 3'h0;
        hs_sync_r  <= 3'h0;
        ls_lvl_r   <= 1'b0;
        hs_lvl_r   <= 1'b0;
        hs_div_r   <= 9'h000;
        lcd_tick_r <= 1'b0;
    end else begin
        ls_sync_r <= {ls_sync_r[1:0], low_speed_oscillator};
        hs_sync_r <= {hs_sync_r[1:0], high_speed_oscillator};
        if (ls_chg) begin
            ls_lvl_r <= ls_sync_r[2];
        end
        if (hs_chg) begin
            hs_lvl_r <= hs_sync_r[2];
        end
        if (hs_rise) begin
            hs_div_r <= (hs_div_r >= hs_last) ? 9'h000 : hs_div_r + 9'd1;
        end
        if (src_hs_r) begin
            lcd_tick_r <= hs_rise && (hs_div_r >= hs_last);
        end else begin
            lcd_tick_r <= ls_rise;
        end
    end
end

// -----------------------------------------------------------------
// Frame divider and common slot timing.
// -----------------------------------------------------------------
wire [8:0]  cnt_nxt    = frame_cnt_r + 9'd1;
wire        slot_start = lcd_tick_r &
                         (duty32 ? (cnt_nxt[3:0] == 4'h0) : (cnt_nxt[4:0] == 5'h00));
wire [4:0]  com_last   = duty32 ? `LFD_NCOM_32 : `LFD_NCOM_16;

reg  [8:0]  frame_cnt_nxt;
reg         frame_out_nxt;

always @* begin
    frame_cnt_nxt = frame_cnt_r;
    frame_out_nxt = frame_out;
    if (lcd_tick_r) begin
        frame_cnt_nxt = cnt_nxt;
        if (frame_cnt_r == 9'h1FF) begin
            frame_out_nxt = ~frame_out;
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        frame_cnt_r <= 9'h000;
        frame_out   <= 1'b0;
    end else begin
        frame_cnt_r <= frame_cnt_nxt;
        frame_out   <= frame_out_nxt;
    end
end

// -----------------------------------------------------------------
// Segment data fetch for the next common slot.
// -----------------------------------------------------------------
reg  [4:0]  fetch_com_r;
reg  [6:0]  fetch_idx_r;
reg         fetch_busy_r;
reg  [71:0] seg_buf_r;

wire [6:0]  nseg     = duty32 ? `LFD_NSEG_32 : `LFD_NSEG_16;
wire [6:0]  seg_log  = seg_rev_r ? (nseg - 7'd1 - fetch_idx_r) : fetch_idx_r;
wire [4:0]  com_log  = common_order_reverse_r ? (com_last - fetch_com_r) : fetch_com_r;
wire [9:0]  fetch_ad = duty32 ? {1'b0, seg_log, com_log[4:3]} :
                                {2'b00, seg_log, com_log[3]};
wire [7:0]  fetch_by = mem[fetch_ad];
wire        pix      = fetch_by[com_log[2:0]];
wire [4:0]  com_next = (fetch_com_r >= com_last) ? 5'h00 : fetch_com_r + 5'd1;

reg  [4:0]  fetch_com_nxt;
reg  [6:0]  fetch_idx_nxt;
reg         fetch_busy_nxt;

always @* begin
    fetch_com_nxt  = fetch_com_r;
    fetch_idx_nxt  = fetch_idx_r;
    fetch_busy_nxt = fetch_busy_r;
    if (slot_start) begin
        fetch_com_nxt  = com_next;
        fetch_idx_nxt  = 7'h00;
        fetch_busy_nxt = 1'b1;
    end else if (fetch_busy_r) begin
        fetch_idx_nxt  = fetch_idx_r + 7'd1;
        fetch_busy_nxt = (fetch_idx_r != nseg - 7'd1);
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        fetch_com_r  <= 5'h00;
        fetch_idx_r  <= 7'h00;
        fetch_busy_r <= 1'b1;
        seg_buf_r    <= {72{1'b0}};
    end else begin
        fetch_com_r  <= fetch_com_nxt;
        fetch_idx_r  <= fetch_idx_nxt;
        fetch_busy_r <= fetch_busy_nxt;
        if (fetch_busy_r && !slot_start) begin
            seg_buf_r[fetch_idx_r] <= pix;
        end
    end
end

// -----------------------------------------------------------------
// Pin drive, updated at each common slot.
// -----------------------------------------------------------------
wire [31:0] com_hot = 32'h0000_0001 << fetch_com_r;
reg  [15:0] seg_hi;
integer     k;

always @* begin
    for (k = 0; k < 16; k = k + 1) begin
        seg_hi[k] = seg_buf_r[71 - k];
    end
end

reg  [4:0]  cur_com_nxt;
reg  [15:0] com_out_nxt;
reg  [55:0] seg_out_nxt;
reg  [15:0] shared_out_nxt;

always @* begin
    cur_com_nxt    = cur_com_r;
    com_out_nxt    = com_out;
    seg_out_nxt    = seg_out;
    shared_out_nxt = shared_out;
    if (slot_start) begin
        cur_com_nxt = fetch_com_r;
        if (!show) begin
            com_out_nxt    = 16'h0000;
            seg_out_nxt    = 56'h00_0000_0000_0000;
            shared_out_nxt = 16'h0000;
        end else begin
            com_out_nxt = com_hot[15:0];
            seg_out_nxt = seg_buf_r[55:0];
            if (duty32) begin
                shared_out_nxt = com_hot[31:16];
            end else begin
                shared_out_nxt = seg_hi;
            end
        end
    end
end

always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
        cur_com_r  <= 5'h00;
        com_out    <= 16'h0000;
        seg_out    <= 56'h00_0000_0000_0000;
        shared_out <= 16'h0000;
    end else begin
        cur_com_r  <= cur_com_nxt;
        com_out    <= com_out_nxt;
        seg_out    <= seg_out_nxt;
        shared_out <= shared_out_nxt;
    end
end

endmodule // lfd_top
